// File: design/video_capture_control_registers.sv
// Purpose: Register bank and line-lock control logic of a video capture front end.
// Assumes: Register requests arrive already decoded from the serial control port on ref_clk_i.
// Notes: Sync and external clock pins are asynchronous and pass two flip-flops first.
`timescale 1ns/1ps
`default_nettype none
module video_capture_control_registers (
    input  wire logic                    ref_clk_i,          // 125 MHz clock
    input  wire logic                    resetn_i,           // Async reset, active low
    input  wire capture_regs_pkg::reg_req_t req_i,           // Decoded register request
    output logic [7:0]                   rdata_o,            // Read data
    output logic                         rdata_valid_o,      // Read data valid pulse
    input  wire logic                    hsync_i,            // Horizontal sync pin
    input  wire logic                    vsync_i,            // Vertical sync pin
    input  wire logic                    ext_pixel_clk_i,    // External pixel clock pin
    output logic                         pixel_tick_o,       // Pixel period pulse
    output logic                         line_lock_o,        // Divided feedback pulse
    output logic [11:0]                  line_divide_ratio_o, // Applied divide ratio
    output logic [1:0]                   oscillator_band_select_o, // Oscillator band
    output logic [3:0]                   post_divide_o,      // Post-oscillator divisor
    output logic [10:0]                  pump_current_o,     // Charge-pump current
    output logic                         external_pixel_clock_select_o, // Clock source
    output logic [4:0]                   sample_phase_o,     // Sampling phase step
    output logic [8:0]                   red_gain_o,         // Applied red gain code
    output logic                         offset_continuous_o, // Offset feedback mode
    output logic                         offset_update_o     // Offset correction pulse
);

    localparam int SYNC_PINS = 3;

    // Pin synchronisers.
    logic [SYNC_PINS-1:0] pin_meta_q;
    logic [SYNC_PINS-1:0] pin_sync_q;
    logic [SYNC_PINS-1:0] pin_prev_q;
    logic [SYNC_PINS-1:0] pin_raw;
    logic [SYNC_PINS-1:0] pin_rise;

    assign pin_raw = {ext_pixel_clk_i, vsync_i, hsync_i};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_PINS; gi++) begin : g_sync
            always_ff @(posedge ref_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    pin_meta_q[gi] <= 1'b0;
                    pin_sync_q[gi] <= 1'b0;
                    pin_prev_q[gi] <= 1'b0;
                end else begin
                    pin_meta_q[gi] <= pin_raw[gi];
                    pin_sync_q[gi] <= pin_meta_q[gi];
                    pin_prev_q[gi] <= pin_sync_q[gi];
                end
            end
            assign pin_rise[gi] = pin_sync_q[gi] & ~pin_prev_q[gi];
        end
    endgenerate

    logic hsync_rise;
    logic vsync_rise;
    logic ext_clk_rise;
    assign hsync_rise   = pin_rise[0];
    assign vsync_rise   = pin_rise[1];
    assign ext_clk_rise = pin_rise[2];

    // Writable register state.
    logic [7:0]                   div_upper_q,  div_upper_d;
    logic [7:0]                   div_lower_q,  div_lower_d;
    logic [11:0]                  ratio_q,      ratio_d;
    capture_regs_pkg::clock_gen_t clk_gen_q,    clk_gen_d;
    logic [7:0]                   phase_q,      phase_d;
    logic [7:0]                   gain_upper_q, gain_upper_d;
    logic [7:0]                   gain_lower_q, gain_lower_d;
    logic [8:0]                   gain_q,       gain_d;
    logic [7:0]                   fixed_a_q,    fixed_a_d;
    logic [7:0]                   fixed_b_q,    fixed_b_d;
    logic [7:0]                   hold_q,       hold_d;
    logic [7:0]                   fixed_c_q,    fixed_c_d;
    logic [7:0]                   fixed_d_q,    fixed_d_d;

    logic wr;
    assign wr = req_i.wr_en;

    always_comb begin
        div_upper_d  = div_upper_q;
        div_lower_d  = div_lower_q;
        ratio_d      = ratio_q;
        clk_gen_d    = clk_gen_q;
        phase_d      = phase_q;
        gain_upper_d = gain_upper_q;
        gain_lower_d = gain_lower_q;
        gain_d       = gain_q;
        fixed_a_d    = fixed_a_q;
        fixed_b_d    = fixed_b_q;
        hold_d       = hold_q;
        fixed_c_d    = fixed_c_q;
        fixed_d_d    = fixed_d_q;
        if (wr) begin
            case (req_i.addr)
                capture_regs_pkg::ADDR_LINE_DIVIDE_UPPER: div_upper_d = req_i.wdata;
                capture_regs_pkg::ADDR_LINE_DIVIDE_LOWER: begin
                    div_lower_d = {req_i.wdata[7:4], 4'h0};
                    ratio_d     = {div_upper_q, req_i.wdata[7:4]};
                end
                capture_regs_pkg::ADDR_CLOCK_GEN_CONTROL: begin
                    clk_gen_d        = capture_regs_pkg::clock_gen_t'(req_i.wdata);
                    clk_gen_d.unused = 2'h0;
                end
                capture_regs_pkg::ADDR_SAMPLE_PHASE: phase_d = {req_i.wdata[7:3], 3'h0};
                capture_regs_pkg::ADDR_RED_GAIN_UPPER: gain_upper_d = {1'b0, req_i.wdata[6:0]};
                capture_regs_pkg::ADDR_RED_GAIN_LOWER: begin
                    gain_lower_d = {req_i.wdata[7:6], 6'h00};
                    gain_d       = {gain_upper_q[6:0], req_i.wdata[7:6]};
                end
                capture_regs_pkg::ADDR_FIXED_A: fixed_a_d = req_i.wdata;
                capture_regs_pkg::ADDR_FIXED_B: fixed_b_d = req_i.wdata;
                capture_regs_pkg::ADDR_OFFSET_HOLD: hold_d = req_i.wdata;
                capture_regs_pkg::ADDR_FIXED_C: fixed_c_d = req_i.wdata;
                capture_regs_pkg::ADDR_FIXED_D: fixed_d_d = req_i.wdata;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_upper_q  <= capture_regs_pkg::RST_LINE_DIVIDE_UPPER;
            div_lower_q  <= capture_regs_pkg::RST_LINE_DIVIDE_LOWER;
            ratio_q      <= capture_regs_pkg::RST_LINE_DIVIDE_RATIO;
            clk_gen_q    <= capture_regs_pkg::clock_gen_t'(capture_regs_pkg::RST_CLOCK_GEN_CONTROL);
            phase_q      <= capture_regs_pkg::RST_SAMPLE_PHASE;
            gain_upper_q <= capture_regs_pkg::RST_RED_GAIN_UPPER;
            gain_lower_q <= capture_regs_pkg::RST_RED_GAIN_LOWER;
            gain_q       <= capture_regs_pkg::RST_RED_GAIN;
            fixed_a_q    <= capture_regs_pkg::RST_FIXED_A;
            fixed_b_q    <= capture_regs_pkg::RST_FIXED_B;
            hold_q       <= capture_regs_pkg::RST_OFFSET_HOLD;
            fixed_c_q    <= capture_regs_pkg::RST_FIXED_C;
            fixed_d_q    <= capture_regs_pkg::RST_FIXED_D;
        end else begin
            div_upper_q  <= div_upper_d;
            div_lower_q  <= div_lower_d;
            ratio_q      <= ratio_d;
            clk_gen_q    <= clk_gen_d;
            phase_q      <= phase_d;
            gain_upper_q <= gain_upper_d;
            gain_lower_q <= gain_lower_d;
            gain_q       <= gain_d;
            fixed_a_q    <= fixed_a_d;
            fixed_b_q    <= fixed_b_d;
            hold_q       <= hold_d;
            fixed_c_q    <= fixed_c_d;
            fixed_d_q    <= fixed_d_d;
        end
    end

    // Line divider and pixel tick.
    logic [11:0] div_cnt_q,  div_cnt_d;
    logic [11:0] ratio_eff;
    logic        tick_q,     tick_d;
    logic        lock_q,     lock_d;
    logic        ext_sel;

    assign ext_sel = clk_gen_q.external_pixel_clock_select;

    // ratios below the minimum act as the minimum.
    assign ratio_eff = (ratio_q < capture_regs_pkg::LINE_DIVIDE_MIN) ?
                       capture_regs_pkg::LINE_DIVIDE_MIN : ratio_q;

    always_comb begin
        div_cnt_d = div_cnt_q;
        lock_d    = 1'b0;
        tick_d    = ext_sel ? ext_clk_rise : 1'b1;
        if (ext_sel) begin
            div_cnt_d = 12'h000;
        end else if (div_cnt_q >= ratio_eff - 12'h001) begin
            div_cnt_d = 12'h000;
            lock_d    = 1'b1;
        end else begin
            div_cnt_d = div_cnt_q + 12'h001;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_cnt_q <= 12'h000;
            tick_q    <= 1'b0;
            lock_q    <= 1'b0;
        end else begin
            div_cnt_q <= div_cnt_d;
            tick_q    <= tick_d;
            lock_q    <= lock_d;
        end
    end

    // Lines per frame measurement.
    logic [11:0] line_cnt_q,  line_cnt_d;
    logic [11:0] lines_q,     lines_d;

    always_comb begin
        line_cnt_d = line_cnt_q;
        lines_d    = lines_q;
        if (vsync_rise) begin
            lines_d    = line_cnt_q;
            line_cnt_d = {11'h000, hsync_rise};
        end else if (hsync_rise && line_cnt_q != capture_regs_pkg::LINE_COUNT_MAX) begin
            line_cnt_d = line_cnt_q + 12'h001;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            line_cnt_q <= 12'h000;
            lines_q    <= 12'h000;
        end else begin
            line_cnt_q <= line_cnt_d;
            lines_q    <= lines_d;
        end
    end

    // Offset feedback update.
    logic armed_q,  armed_d;
    logic upd_q,    upd_d;
    logic cont;
    logic hold_wr;

    assign cont    = hold_q[capture_regs_pkg::POS_OFFSET_CONTINUOUS];
    assign hold_wr = wr && req_i.addr == capture_regs_pkg::ADDR_OFFSET_HOLD;

    always_comb begin
        armed_d = armed_q;
        upd_d   = 1'b0;
        if (vsync_rise && (cont || armed_q)) begin
            upd_d   = 1'b1;
            armed_d = 1'b0;
        end
        // A new write re-arms the single update; it wins over the consume.
        if (hold_wr) begin
            armed_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            armed_q <= 1'b1;
            upd_q   <= 1'b0;
        end else begin
            armed_q <= armed_d;
            upd_q   <= upd_d;
        end
    end

    // Registered control outputs.
    logic [3:0]  post_div_q;
    logic [10:0] pump_q;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            post_div_q <= 4'h0;
            pump_q     <= 11'h000;
        end else begin
            post_div_q <= capture_regs_pkg::POST_DIVIDE_TABLE[clk_gen_q.oscillator_band_select];
            pump_q     <= capture_regs_pkg::PUMP_CURRENT_TABLE[clk_gen_q.pump_current_code];
        end
    end

    // Register read port.
    logic [7:0] rdata_q, rdata_d;
    logic       rvalid_q;

    always_comb begin
        rdata_d = rdata_q;
        if (req_i.rd_en) begin
            case (req_i.addr)
                capture_regs_pkg::ADDR_SILICON_REVISION:  rdata_d = capture_regs_pkg::SILICON_REVISION_VALUE;
                capture_regs_pkg::ADDR_LINE_DIVIDE_UPPER: rdata_d = div_upper_q;
                capture_regs_pkg::ADDR_LINE_DIVIDE_LOWER: rdata_d = div_lower_q;
                capture_regs_pkg::ADDR_CLOCK_GEN_CONTROL: rdata_d = clk_gen_q;
                capture_regs_pkg::ADDR_SAMPLE_PHASE:      rdata_d = phase_q;
                capture_regs_pkg::ADDR_RED_GAIN_UPPER:    rdata_d = gain_upper_q;
                capture_regs_pkg::ADDR_RED_GAIN_LOWER:    rdata_d = gain_lower_q;
                capture_regs_pkg::ADDR_LINES_UPPER:       rdata_d = lines_q[11:4];
                capture_regs_pkg::ADDR_LINES_LOWER:       rdata_d = {lines_q[3:0], 4'h0};
                capture_regs_pkg::ADDR_FIXED_A:           rdata_d = fixed_a_q;
                capture_regs_pkg::ADDR_FIXED_B:           rdata_d = fixed_b_q;
                capture_regs_pkg::ADDR_RESERVED_A:        rdata_d = capture_regs_pkg::RESERVED_READ_VALUE;
                capture_regs_pkg::ADDR_RESERVED_B:        rdata_d = capture_regs_pkg::RESERVED_READ_VALUE;
                capture_regs_pkg::ADDR_OFFSET_HOLD:       rdata_d = hold_q;
                capture_regs_pkg::ADDR_FIXED_C:           rdata_d = fixed_c_q;
                capture_regs_pkg::ADDR_FIXED_D:           rdata_d = fixed_d_q;
                default:                                  rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= req_i.rd_en;
        end
    end

    assign rdata_o                       = rdata_q;
    assign rdata_valid_o                 = rvalid_q;
    assign pixel_tick_o                  = tick_q;
    assign line_lock_o                   = lock_q;
    assign line_divide_ratio_o           = ratio_q;
    assign oscillator_band_select_o      = clk_gen_q.oscillator_band_select;
    assign post_divide_o                 = post_div_q;
    assign pump_current_o                = pump_q;
    assign external_pixel_clock_select_o = clk_gen_q.external_pixel_clock_select;
    assign sample_phase_o                = phase_q[7:capture_regs_pkg::POS_PHASE_LOW];
    assign red_gain_o                    = gain_q;
    assign offset_continuous_o           = cont;
    assign offset_update_o               = upd_q;

endmodule : video_capture_control_registers
`default_nettype wire

// File: shared/capture_regs_pkg.sv
// Purpose: Constants and types for the video capture control register bank.
// Assumes: Byte-wide registers, 8-bit register addresses from the serial control port decoder.
// Notes: Every offset, reset value and table lives here once; the divide, phase and gain data field positions are written out in the bank.
package capture_regs_pkg;

    localparam logic [7:0] ADDR_SILICON_REVISION  = 8'h00;
    localparam logic [7:0] ADDR_LINE_DIVIDE_UPPER = 8'h01;
    localparam logic [7:0] ADDR_LINE_DIVIDE_LOWER = 8'h02;
    localparam logic [7:0] ADDR_CLOCK_GEN_CONTROL = 8'h03;
    localparam logic [7:0] ADDR_SAMPLE_PHASE      = 8'h04;
    localparam logic [7:0] ADDR_RED_GAIN_UPPER    = 8'h05;
    localparam logic [7:0] ADDR_RED_GAIN_LOWER    = 8'h06;
    localparam logic [7:0] ADDR_LINES_UPPER       = 8'h26;
    localparam logic [7:0] ADDR_LINES_LOWER       = 8'h27;
    localparam logic [7:0] ADDR_FIXED_A           = 8'h28;
    localparam logic [7:0] ADDR_FIXED_B           = 8'h29;
    localparam logic [7:0] ADDR_RESERVED_A        = 8'h2A;
    localparam logic [7:0] ADDR_RESERVED_B        = 8'h2B;
    localparam logic [7:0] ADDR_OFFSET_HOLD       = 8'h2C;
    localparam logic [7:0] ADDR_FIXED_C           = 8'h2D;
    localparam logic [7:0] ADDR_FIXED_D           = 8'h2E;

    // Arbitrary revision value, not tied to any real part.
    localparam logic [7:0] SILICON_REVISION_VALUE = 8'h5A;
    localparam logic [7:0] RESERVED_READ_VALUE    = 8'h00;

    localparam logic [7:0]  RST_LINE_DIVIDE_UPPER = 8'h69;
    localparam logic [7:0]  RST_LINE_DIVIDE_LOWER = 8'hD0;
    localparam logic [11:0] RST_LINE_DIVIDE_RATIO = 12'h69D;
    localparam logic [7:0]  RST_CLOCK_GEN_CONTROL = 8'h48;
    localparam logic [7:0]  RST_SAMPLE_PHASE      = 8'h80;
    localparam logic [7:0]  RST_RED_GAIN_UPPER    = 8'h40;
    localparam logic [7:0]  RST_RED_GAIN_LOWER    = 8'h00;
    localparam logic [8:0]  RST_RED_GAIN          = 9'h100;
    localparam logic [7:0]  RST_FIXED_A           = 8'hBF;
    localparam logic [7:0]  RST_FIXED_B           = 8'h02;
    localparam logic [7:0]  RST_OFFSET_HOLD       = 8'h00;
    localparam logic [7:0]  RST_FIXED_C           = 8'hF0;
    localparam logic [7:0]  RST_FIXED_D           = 8'hF0;

    localparam int          POS_OFFSET_CONTINUOUS = 4;
    localparam int          POS_PHASE_LOW         = 3;
    localparam logic [11:0] LINE_DIVIDE_MIN       = 12'h002;
    localparam logic [11:0] LINE_COUNT_MAX        = 12'hFFF;

    // Charge-pump current per code, in the loop's current units.
    localparam logic [7:0][10:0] PUMP_CURRENT_TABLE = {
        11'h5DC, 11'h2EE, 11'h1F4, 11'h15E, 11'h0FA, 11'h096, 11'h064, 11'h032};
    // Post-oscillator divisor per band: slow bands run the oscillator fast.
    localparam logic [3:0][3:0]  POST_DIVIDE_TABLE  = {4'h1, 4'h2, 4'h4, 4'h8};

    typedef struct packed {
        logic [1:0] oscillator_band_select;
        logic [2:0] pump_current_code;
        logic       external_pixel_clock_select;
        logic [1:0] unused;
    } clock_gen_t;

    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage : capture_regs_pkg

// File: tb/capture_regs_checker.sv
// Purpose: Port-level checks of the capture register bank.
// Assumes: One clock domain, reset active low.
// Notes: Bound to every instance of the bank.
`timescale 1ns/1ps
`default_nettype none
module capture_regs_checker (
    input wire logic                       ref_clk_i,                     // Clock
    input wire logic                       resetn_i,                      // Reset, active low
    input wire capture_regs_pkg::reg_req_t req_i,                         // Request
    input wire logic [7:0]                 rdata_o,                       // Read data
    input wire logic                       rdata_valid_o,                 // Read valid
    input wire logic                       line_lock_o,                   // Divided pulse
    input wire logic [11:0]                line_divide_ratio_o,           // Applied ratio
    input wire logic [1:0]                 oscillator_band_select_o,      // Band
    input wire logic [3:0]                 post_divide_o,                 // Post divisor
    input wire logic                       external_pixel_clock_select_o, // Clock source
    input wire logic [4:0]                 sample_phase_o,                // Phase
    input wire logic                       offset_continuous_o,           // Offset mode
    input wire logic                       offset_update_o                // Offset pulse
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    AST_READ_ANSWER: assert property (req_i.rd_en |=> rdata_valid_o)
        else $error("read not answered");
    AST_REVISION: assert property (req_i.rd_en && req_i.addr == 8'h00
        |=> rdata_o == capture_regs_pkg::SILICON_REVISION_VALUE) else $error("bad revision");
    AST_UPPER_STAGED: assert property (req_i.wr_en && req_i.addr == 8'h01
        |=> $stable(line_divide_ratio_o)) else $error("ratio applied early");
    AST_LOWER_APPLY: assert property (req_i.wr_en && req_i.addr == 8'h02
        |=> line_divide_ratio_o[3:0] == $past(req_i.wdata[7:4])) else $error("ratio low bits");
    AST_BAND: assert property (req_i.wr_en && req_i.addr == 8'h03
        |=> oscillator_band_select_o == $past(req_i.wdata[7:6])) else $error("band");
    AST_POST_DIV: assert property (req_i.wr_en && req_i.addr == 8'h03
        |-> ##2 post_divide_o == (4'h8 >> $past(req_i.wdata[7:6], 2))) else $error("post divide");
    AST_EXT_SEL: assert property (req_i.wr_en && req_i.addr == 8'h03
        |=> external_pixel_clock_select_o == $past(req_i.wdata[2])) else $error("clock source");
    AST_PHASE: assert property (req_i.wr_en && req_i.addr == 8'h04
        |=> sample_phase_o == $past(req_i.wdata[7:3])) else $error("phase");
    AST_OFFSET_MODE: assert property (req_i.wr_en && req_i.addr == 8'h2C
        |=> offset_continuous_o == $past(req_i.wdata[4])) else $error("offset mode");
    AST_EXT_NO_LOCK: assert property (external_pixel_clock_select_o
        && $past(external_pixel_clock_select_o) |-> !line_lock_o) else $error("lock in ext mode");

    COV_LOCK: cover property (line_lock_o);
    COV_OFFSET: cover property (offset_update_o);
    COV_COUNT_READ: cover property (req_i.rd_en && req_i.addr == 8'h26);
endmodule : capture_regs_checker

bind video_capture_control_registers capture_regs_checker u_checker (.ref_clk_i, .resetn_i,
    .req_i, .rdata_o, .rdata_valid_o, .line_lock_o, .line_divide_ratio_o, .oscillator_band_select_o,
    .post_divide_o, .external_pixel_clock_select_o, .sample_phase_o, .offset_continuous_o,
    .offset_update_o);
`default_nettype wire

// File: tb/sync_source.sv
// Purpose: Sync pin source standing in for the video timing generator.
// Assumes: Pins change just after a rising edge of the bank clock.
// Notes: The external pixel clock runs free, unrelated to the bank clock.
`timescale 1ns/1ps
`default_nettype none
module sync_source (
    input  wire logic ref_clk_i, // Bank clock
    output var logic  hsync_o,   // Horizontal sync pin
    output var logic  vsync_o,   // Vertical sync pin
    output var logic  ext_clk_o  // External pixel clock pin
);
    initial begin
        hsync_o = 1'b0;
        vsync_o = 1'b0;
        ext_clk_o = 1'b0;
    end
    // An odd half period keeps the synchroniser away from a fixed phase.
    always #11 ext_clk_o = ~ext_clk_o;

    task automatic frame(input int lines);
        repeat (lines) begin
            @(posedge ref_clk_i);
            hsync_o <= 1'b1;
            repeat (3) @(posedge ref_clk_i);
            hsync_o <= 1'b0;
            repeat (2) @(posedge ref_clk_i);
        end
        @(posedge ref_clk_i);
        vsync_o <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        vsync_o <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
    endtask : frame
endmodule : sync_source
`default_nettype wire

// File: tb/video_capture_control_registers_tb.sv
// Purpose: Self-checking bench of the capture register bank.
// Assumes: Requests arrive already decoded, one per cycle.
// Notes: Sync pins come from the sync source model.
`timescale 1ns/1ps
`default_nettype none
module video_capture_control_registers_tb;
    logic                       ref_clk = 1'b0;
    logic                       resetn  = 1'b0;
    capture_regs_pkg::reg_req_t req     = '0;
    logic [7:0]  rdata;
    logic [11:0] ratio;
    logic [10:0] pump;
    logic [8:0]  gain;
    logic [4:0]  phase;
    logic [3:0]  pdiv;
    logic [1:0]  band;
    logic        rvalid, hsync, vsync, ext_clk, lock, ext_sel, ocont, oupd, tick;
    int          mismatches = 0;
    int          n_tests = 0;
    int          cycles = 0;
    int          n_upd = 0;
    int          n_tick = 0;
    int          i;
    logic [7:0]  ra[17] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h26, 8'h27,
                            8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h7F};
    logic [7:0]  rv[17] = '{8'h5A, 8'h69, 8'hD0, 8'h48, 8'h80, 8'h40, 8'h00, 8'h00, 8'h00,
                            8'hBF, 8'h02, 8'h00, 8'h00, 8'h00, 8'hF0, 8'hF0, 8'h00};
    logic [7:0]  fa[4] = '{8'h28, 8'h29, 8'h2D, 8'h2E};
    logic [7:0]  fv[4] = '{8'hBF, 8'h02, 8'hE8, 8'hE0};
    logic [11:0] pump_ua[8] = '{12'd50, 12'd100, 12'd150, 12'd250, 12'd350, 12'd500, 12'd750, 12'd1500};

    always #4 ref_clk = ~ref_clk;

    video_capture_control_registers dut (.ref_clk_i(ref_clk), .resetn_i(resetn), .req_i(req),
        .rdata_o(rdata), .rdata_valid_o(rvalid), .hsync_i(hsync), .vsync_i(vsync),
        .ext_pixel_clk_i(ext_clk), .pixel_tick_o(tick), .line_lock_o(lock), .line_divide_ratio_o(ratio),
        .oscillator_band_select_o(band), .post_divide_o(pdiv), .pump_current_o(pump),
        .external_pixel_clock_select_o(ext_sel), .sample_phase_o(phase), .red_gain_o(gain),
        .offset_continuous_o(ocont), .offset_update_o(oupd));

    sync_source src (.ref_clk_i(ref_clk), .hsync_o(hsync), .vsync_o(vsync), .ext_clk_o(ext_clk));

    task automatic finish_test();
        if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        req <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
        @(posedge ref_clk);
        req <= '0;
        #1;
        chk({3'h0, rvalid, rdata}, {4'h1, e});
    endtask : rd

    task automatic wait2();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : wait2

    // The first two pulses may still follow the old ratio, so only the third gap counts.
    task automatic lock_gap(input logic [11:0] exp);
        int n;
        n = 0;
        repeat (3) begin
            n = 0;
            do begin
                @(posedge ref_clk);
                #1;
                n++;
            end while (lock !== 1'b1 && n < 5000);
        end
        chk(n[11:0], exp);
    endtask : lock_gap

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (oupd === 1'b1) n_upd <= n_upd + 1;
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        resetn <= 1'b1;
        wait2();
        chk(ratio, 12'd1693);
        chk({3'h0, gain}, 12'h100);
        chk({7'h0, phase}, 12'd16);
        chk({10'h0, band}, 12'h001);
        chk({8'h0, pdiv}, 12'h004);
        chk({1'b0, pump}, 12'd100);
        chk({11'h0, ext_sel}, 12'h000);
        chk({11'h0, tick}, 12'h001);
        for (i = 0; i < 17; i++) rd(ra[i], rv[i]);
        wr(8'h00, 8'hFF);
        rd(8'h00, 8'h5A);
        for (i = 0; i < 4; i++) begin
            wr(fa[i], fv[i]);
            rd(fa[i], fv[i]);
        end
        wr(8'h01, 8'h00);
        wait2();
        chk(ratio, 12'd1693);
        rd(8'h01, 8'h00);
        wr(8'h02, 8'h50);
        wait2();
        chk(ratio, 12'h005);
        lock_gap(12'd5);
        wr(8'h02, 8'h20);
        lock_gap(12'd2);
        for (i = 0; i < 8; i++) begin
            wr(8'h03, {i[1:0], i[2:0], 3'b000});
            wait2();
            chk({10'h0, band}, {10'h0, i[1:0]});
            chk({8'h0, pdiv}, 12'h8 >> i[1:0]);
            chk({1'b0, pump}, pump_ua[i]);
        end
        wr(8'h03, 8'h4C);
        wr(8'h04, 8'hF8);
        wait2();
        chk({11'h0, ext_sel}, 12'h001);
        chk({7'h0, phase}, 12'h01F);
        i = 0;
        n_tick = 0;
        repeat (20) begin
            @(posedge ref_clk);
            #1;
            if (lock === 1'b1) i++;
            if (tick === 1'b1) n_tick++;
        end
        chk(i[11:0], 12'h000);
        // The pin runs free at 22 ns, so 20 cycles hold seven or eight of its rises.
        chk({11'h0, n_tick >= 7 && n_tick <= 8}, 12'h001);
        wr(8'h03, 8'h48);
        wr(8'h05, 8'h7F);
        wait2();
        chk({3'h0, gain}, 12'h100);
        wr(8'h06, 8'hC0);
        wait2();
        chk({3'h0, gain}, 12'h1FF);
        src.frame(5);
        src.frame(20);
        rd(8'h26, 8'h01);
        rd(8'h27, 8'h40);
        chk(n_upd[11:0], 12'd1);
        wr(8'h2C, 8'h00);
        src.frame(2);
        src.frame(2);
        chk(n_upd[11:0], 12'd2);
        wr(8'h2C, 8'h10);
        wait2();
        chk({11'h0, ocont}, 12'h001);
        src.frame(2);
        src.frame(2);
        chk(n_upd[11:0], 12'd4);
        finish_test();
    end
endmodule : video_capture_control_registers_tb
`default_nettype wire
